// [lsrc_pkg.sv]
// Summary of operation
// - Contention descriptor: tag, length, group, wait, limit, bound
// - Length byte counts following bytes; marks end
// - Contention values only for own frame group
// - No logon reply before wait: burst collided
// - Abandon logon when failed attempts reach limit
// - Else random back-off up to bound, then retry
// - Waits counted in clock-reference intervals, 32 bits
// - Correction descriptor: tag, length, waits, two limits
// - Coarse: no correction in wait, acquisition failed
// - Fine/maintenance: no correction in wait, burst failed
// - Coarse loss limit reached: back to off
// - Fine loss limit reached: back to off
// - No reserved bits in the fields; every field bit is used
package lsrc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_GROUP   = 8'h04;
    localparam logic [7:0] OFS_TAGS    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_LWAIT   = 8'h10;
    localparam logic [7:0] OFS_BACKOFF = 8'h14;
    localparam logic [7:0] OFS_CWAIT   = 8'h18;
    localparam logic [7:0] OFS_FWAIT   = 8'h1c;
    localparam logic [7:0] OFS_LIMITS  = 8'h20;

    localparam int CTRL_SYNC_START  = 0;
    localparam int CTRL_LOGON_START = 1;
    localparam int CTRL_SYNC_STOP   = 2;
    localparam int CTRL_LOGON_STOP  = 3;
    localparam int TAGS_CONT_LSB    = 0;
    localparam int TAGS_CORR_LSB    = 8;
    localparam int ST_SYNC_LSB      = 0;
    localparam int ST_LOGON_LSB     = 4;
    localparam int ST_ATT_LSB       = 8;
    localparam int ST_CLOSS_LSB     = 16;
    localparam int ST_FLOSS_LSB     = 24;
    localparam int LIM_LOGON_LSB    = 0;
    localparam int LIM_COARSE_LSB   = 8;
    localparam int LIM_FINE_LSB     = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_GROUP    = 8'h00;
    localparam logic [7:0]  RST_CONT_TAG = 8'ha0;
    localparam logic [7:0]  RST_CORR_TAG = 8'ha1;
    localparam logic [31:0] RST_WAIT     = 32'h0000_ffff;
    localparam logic [7:0]  RST_LIMIT    = 8'h03;
    localparam logic [31:0] LFSR_SEED    = 32'h1357_9bdf;
    localparam logic [31:0] LFSR_TAPS    = 32'h8020_0003;

    // ------------------------------------------------------------
    // Descriptor layout, bytes after the length byte
    // ------------------------------------------------------------
    localparam logic [7:0] DESC_PAYLOAD = 8'h0a;
    localparam int         BUF_W        = 80;
    // Full scale of a 32-bit wait in milliseconds
    localparam int         WAIT_FULL_MS = 93200;

    typedef enum logic [1:0] {
        SY_OFF, SY_COARSE, SY_FINE, SY_MAINT
    } lsrc_sync_e;

    typedef enum logic [2:0] {
        LG_IDLE, LG_ARMED, LG_WAIT, LG_BACK, LG_DONE, LG_GIVEUP
    } lsrc_logon_e;

endpackage

// [lsrc_tmr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lsrc_tmr_if;
    logic        start;
    logic        stop;
    logic        tick;
    logic [31:0] load;
    logic        expired;
    logic        running;
    modport ctl (output start, stop, tick, load, input expired, running);
    modport tmr (input start, stop, tick, load, output expired, running);
endinterface
`default_nettype wire

// [lsrc_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module lsrc_timer
    import lsrc_pkg::*;
(
    input  wire logic clk,     // System clock
    input  wire logic nrst,    // Sync reset, active low
    lsrc_tmr_if.tmr   tif      // Start, stop, tick and expiry
);
    logic [31:0] cnt_reg, cnt_next;
    logic        run_reg, run_next;

    always_comb begin
        cnt_next    = cnt_reg;
        run_next    = run_reg;
        // Expiry ignores start and stop, so a caller may reload on it
        tif.expired = run_reg && tif.tick && (cnt_reg <= 32'h1);
        if (tif.stop) begin
            run_next = 1'b0;
        end else if (tif.start) begin
            cnt_next = tif.load;
            run_next = 1'b1;
        end else if (tif.expired) begin
            run_next = 1'b0;
        end else if (run_reg && tif.tick) begin
            cnt_next = cnt_reg - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_reg <= 32'h0;
            run_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    assign tif.running = run_reg;

    AST_TMR_TICK: assert property (@(posedge clk) disable iff (!nrst)
        run_reg && !tif.tick && !tif.start && !tif.stop |=> $stable(cnt_reg))
        else $error("Timer moved without a reference tick");
endmodule
`default_nettype wire

// [lsrc_lfsr.sv]
`timescale 1ns/100ps
`default_nettype none
module lsrc_lfsr
    import lsrc_pkg::*;
(
    input  wire logic        clk,   // System clock
    input  wire logic        nrst,  // Sync reset, active low
    output logic      [31:0] rnd    // Pseudo-random word
);
    logic [31:0] lfsr_reg, lfsr_next;

    always_comb begin
        lfsr_next = {1'b0, lfsr_reg[31:1]};
        if (lfsr_reg[0]) begin
            lfsr_next = lfsr_next ^ LFSR_TAPS;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lfsr_reg <= LFSR_SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    assign rnd = lfsr_reg;
endmodule
`default_nettype wire

// [lsrc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module lsrc_top
    import lsrc_pkg::*;
(
    input  wire logic        clk,          // 50 MHz system clock
    input  wire logic        nrst,         // Sync reset, active low
    input  wire logic        hsel,         // AHB select
    input  wire logic [31:0] haddr,        // AHB address
    input  wire logic [1:0]  htrans,       // AHB transfer type
    input  wire logic        hwrite,       // AHB write
    input  wire logic [2:0]  hsize,        // AHB size
    input  wire logic [31:0] hwdata,       // AHB write data
    input  wire logic        hready,       // AHB bus ready
    output logic             hreadyout,    // AHB slave ready
    output logic      [31:0] hrdata,       // AHB read data
    output logic             hresp,        // AHB response
    input  wire logic        desc_valid,   // Descriptor byte valid
    input  wire logic        desc_first,   // Byte is a descriptor tag
    input  wire logic [7:0]  desc_byte,    // Descriptor byte
    input  wire logic        pcr_tick,     // One reference interval
    input  wire logic        logon_sent,   // Logon burst went out
    input  wire logic        logon_reply,  // Logon response came
    input  wire logic        acq_sent,     // Acquisition burst out
    input  wire logic        sync_sent,    // Timing-hold burst out
    input  wire logic        corr_rcvd,    // Correction arrived
    output logic             logon_req,    // Send a logon burst
    output logic             logon_abandon,// Logon given up
    output logic             sync_active   // Not in off/stand-by
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        a_wr_reg, a_wr_next;
    logic [7:0]  a_addr_reg, a_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [7:0]  group_reg, group_next;
    logic [15:0] tags_reg, tags_next;
    logic [31:0] rd_mux;
    logic        wr_ctrl;
    logic        addr_ok;

    // Parameter store
    logic [31:0] lwait_reg, lwait_next, back_reg, back_next;
    logic [31:0] cwait_reg, cwait_next, fwait_reg, fwait_next;
    logic [7:0]  llim_reg, llim_next, clim_reg, clim_next;
    logic [7:0]  flim_reg, flim_next;

    // Counters and states
    lsrc_sync_e  sy_reg, sy_next;
    lsrc_logon_e lg_reg, lg_next;
    logic [7:0]  att_reg, att_next, closs_reg, closs_next;
    logic [7:0]  floss_reg, floss_next;
    logic        req_reg, req_next;

    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_ctrl = a_wr_reg && (a_addr_reg == OFS_CTRL);

    always_comb begin
        rd_mux = 32'h0;
        unique case (haddr[7:0])
            OFS_GROUP:   rd_mux = {24'h0, group_reg};
            OFS_TAGS:    rd_mux = {16'h0, tags_reg};
            OFS_STATUS: begin
                rd_mux[ST_SYNC_LSB +: 2]  = sy_reg;
                rd_mux[ST_LOGON_LSB +: 3] = lg_reg;
                rd_mux[ST_ATT_LSB +: 8]   = att_reg;
                rd_mux[ST_CLOSS_LSB +: 8] = closs_reg;
                rd_mux[ST_FLOSS_LSB +: 8] = floss_reg;
            end
            OFS_LWAIT:   rd_mux = lwait_reg;
            OFS_BACKOFF: rd_mux = back_reg;
            OFS_CWAIT:   rd_mux = cwait_reg;
            OFS_FWAIT:   rd_mux = fwait_reg;
            OFS_LIMITS: begin
                rd_mux[LIM_LOGON_LSB +: 8]  = llim_reg;
                rd_mux[LIM_COARSE_LSB +: 8] = clim_reg;
                rd_mux[LIM_FINE_LSB +: 8]   = flim_reg;
            end
            default:     rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        a_wr_next   = 1'b0;
        a_addr_next = a_addr_reg;
        hrdata_next = hrdata_reg;
        group_next  = group_reg;
        tags_next   = tags_reg;
        if (addr_ok) begin
            a_wr_next   = hwrite;
            a_addr_next = haddr[7:0];
            if (!hwrite) begin
                hrdata_next = rd_mux;
            end
        end
        if (a_wr_reg && a_addr_reg == OFS_GROUP) begin
            group_next = hwdata[7:0];
        end
        if (a_wr_reg && a_addr_reg == OFS_TAGS) begin
            tags_next = hwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            a_wr_reg   <= 1'b0;
            a_addr_reg <= 8'h0;
            hrdata_reg <= 32'h0;
            group_reg  <= RST_GROUP;
            tags_reg   <= {RST_CORR_TAG, RST_CONT_TAG};
        end else begin
            a_wr_reg   <= a_wr_next;
            a_addr_reg <= a_addr_next;
            hrdata_reg <= hrdata_next;
            group_reg  <= group_next;
            tags_reg   <= tags_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // ------------------------------------------------------------
    // Descriptor parser
    // ------------------------------------------------------------
    logic             p_act_reg, p_act_next;
    logic [7:0]       p_idx_reg, p_idx_next;
    logic [7:0]       p_tag_reg, p_tag_next;
    logic [7:0]       p_len_reg, p_len_next;
    logic [BUF_W-1:0] p_buf_reg, p_buf_next;
    logic             p_last;
    logic             cont_apply, corr_apply;

    always_comb begin
        p_act_next = p_act_reg;
        p_idx_next = p_idx_reg;
        p_tag_next = p_tag_reg;
        p_len_next = p_len_reg;
        p_buf_next = p_buf_reg;
        p_last     = 1'b0;
        if (desc_valid && desc_first) begin
            p_act_next = 1'b1;
            p_tag_next = desc_byte;
            p_idx_next = 8'h1;
        end else if (desc_valid && p_act_reg) begin
            p_idx_next = p_idx_reg + 8'h1;
            if (p_idx_reg == 8'h1) begin
                p_len_next = desc_byte;
                p_act_next = (desc_byte != 8'h0);
            end else begin
                // Trailing bytes past the known fields are skipped
                if (p_idx_reg - 8'h2 < DESC_PAYLOAD) begin
                    p_buf_next = {p_buf_reg[BUF_W-9:0], desc_byte};
                end
                if (p_idx_reg - 8'h1 == p_len_reg) begin
                    p_last     = 1'b1;
                    p_act_next = 1'b0;
                end
            end
        end
    end

    // Short descriptors are dropped rather than half applied
    assign cont_apply = p_last && p_tag_reg == tags_reg[TAGS_CONT_LSB +: 8]
        && p_len_reg >= DESC_PAYLOAD
        && p_buf_next[79:72] == group_reg;
    assign corr_apply = p_last && p_tag_reg == tags_reg[TAGS_CORR_LSB +: 8]
        && p_len_reg >= DESC_PAYLOAD;

    // No reserved bits sit in these fields; none are ever read
    always_comb begin
        lwait_next = lwait_reg;
        llim_next  = llim_reg;
        back_next  = back_reg;
        cwait_next = cwait_reg;
        fwait_next = fwait_reg;
        clim_next  = clim_reg;
        flim_next  = flim_reg;
        if (cont_apply) begin
            lwait_next = p_buf_next[71:40];
            llim_next  = p_buf_next[39:32];
            back_next  = p_buf_next[31:0];
        end
        if (corr_apply) begin
            cwait_next = p_buf_next[79:48];
            fwait_next = p_buf_next[47:16];
            clim_next  = p_buf_next[15:8];
            flim_next  = p_buf_next[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_act_reg <= 1'b0;
            p_idx_reg <= 8'h0;
            p_tag_reg <= 8'h0;
            p_len_reg <= 8'h0;
            p_buf_reg <= '0;
            lwait_reg <= RST_WAIT;
            back_reg  <= RST_WAIT;
            cwait_reg <= RST_WAIT;
            fwait_reg <= RST_WAIT;
            llim_reg  <= RST_LIMIT;
            clim_reg  <= RST_LIMIT;
            flim_reg  <= RST_LIMIT;
        end else begin
            p_act_reg <= p_act_next;
            p_idx_reg <= p_idx_next;
            p_tag_reg <= p_tag_next;
            p_len_reg <= p_len_next;
            p_buf_reg <= p_buf_next;
            lwait_reg <= lwait_next;
            back_reg  <= back_next;
            cwait_reg <= cwait_next;
            fwait_reg <= fwait_next;
            llim_reg  <= llim_next;
            clim_reg  <= clim_next;
            flim_reg  <= flim_next;
        end
    end

    // ------------------------------------------------------------
    // Timers and random source
    // ------------------------------------------------------------
    lsrc_tmr_if lt ();
    lsrc_tmr_if st ();
    logic [31:0] rnd, smear, cand, back_pick;

    lsrc_timer u_ltmr (.clk(clk), .nrst(nrst), .tif(lt));
    lsrc_timer u_stmr (.clk(clk), .nrst(nrst), .tif(st));
    lsrc_lfsr  u_rnd  (.clk(clk), .nrst(nrst), .rnd(rnd));

    // Mask then fold keeps the pick within bound without a divider
    always_comb begin
        smear = back_reg;
        for (int i = 1; i < 32; i = i * 2) begin
            smear = smear | (smear >> i);
        end
        cand      = rnd & smear;
        back_pick = (cand > back_reg) ? cand - back_reg - 32'h1 : cand;
    end

    // ------------------------------------------------------------
    // Logon retry control
    // ------------------------------------------------------------
    always_comb begin
        lg_next  = lg_reg;
        att_next = att_reg;
        req_next = 1'b0;
        lt.start = 1'b0;
        lt.stop  = 1'b0;
        lt.tick  = pcr_tick;
        lt.load  = lwait_reg;
        if (wr_ctrl && hwdata[CTRL_LOGON_STOP]) begin
            lg_next  = LG_IDLE;
            lt.stop  = 1'b1;
        end else if (wr_ctrl && hwdata[CTRL_LOGON_START]) begin
            lg_next  = LG_ARMED;
            att_next = 8'h0;
            req_next = 1'b1;
            lt.stop  = 1'b1;
        end else begin
            unique case (lg_reg)
                LG_ARMED: if (logon_sent) begin
                    lt.start = 1'b1;
                    lg_next  = LG_WAIT;
                end
                LG_WAIT: if (logon_reply) begin
                    lt.stop = 1'b1;
                    lg_next = LG_DONE;
                end else if (lt.expired) begin
                    att_next = att_reg + 8'h1;
                    if (att_reg + 8'h1 >= llim_reg) begin
                        lg_next = LG_GIVEUP;
                    end else begin
                        lt.start = 1'b1;
                        lt.load  = back_pick;
                        lg_next  = LG_BACK;
                    end
                end
                LG_BACK: if (lt.expired) begin
                    req_next = 1'b1;
                    lg_next  = LG_ARMED;
                end
                default: lg_next = lg_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Synchronisation loss control
    // ------------------------------------------------------------
    always_comb begin
        sy_next    = sy_reg;
        closs_next = closs_reg;
        floss_next = floss_reg;
        st.start   = 1'b0;
        st.stop    = 1'b0;
        st.tick    = pcr_tick;
        st.load    = (sy_reg == SY_COARSE) ? cwait_reg : fwait_reg;
        if (wr_ctrl && hwdata[CTRL_SYNC_STOP]) begin
            sy_next = SY_OFF;
            st.stop = 1'b1;
        end else begin
            unique case (sy_reg)
                SY_OFF: if (wr_ctrl && hwdata[CTRL_SYNC_START]) begin
                    sy_next    = SY_COARSE;
                    closs_next = 8'h0;
                    floss_next = 8'h0;
                end
                SY_COARSE: if (st.running && corr_rcvd) begin
                    st.stop    = 1'b1;
                    closs_next = 8'h0;
                    sy_next    = SY_FINE;
                end else if (st.expired) begin
                    closs_next = closs_reg + 8'h1;
                    if (closs_reg + 8'h1 >= clim_reg) begin
                        sy_next = SY_OFF;
                    end
                end else if (acq_sent) begin
                    st.start = 1'b1;
                end
                SY_FINE, SY_MAINT: if (st.running && corr_rcvd) begin
                    st.stop    = 1'b1;
                    floss_next = 8'h0;
                    sy_next    = SY_MAINT;
                end else if (st.expired) begin
                    floss_next = floss_reg + 8'h1;
                    if (floss_reg + 8'h1 >= flim_reg) begin
                        sy_next = SY_OFF;
                    end
                end else if (sync_sent) begin
                    st.start = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lg_reg    <= LG_IDLE;
            att_reg   <= 8'h0;
            req_reg   <= 1'b0;
            sy_reg    <= SY_OFF;
            closs_reg <= 8'h0;
            floss_reg <= 8'h0;
        end else begin
            lg_reg    <= lg_next;
            att_reg   <= att_next;
            req_reg   <= req_next;
            sy_reg    <= sy_next;
            closs_reg <= closs_next;
            floss_reg <= floss_next;
        end
    end

    assign logon_req     = req_reg;
    assign logon_abandon = (lg_reg == LG_GIVEUP);
    assign sync_active   = (sy_reg != SY_OFF);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CONT_FIELDS: assert property (cont_apply |=>
        lwait_reg == $past(p_buf_next[71:40])
        && back_reg == $past(p_buf_next[31:0])) else $error("Bad parse");
    AST_LEN_END: assert property (p_act_reg && desc_valid && !desc_first
        && p_idx_reg > 8'h1 && p_idx_reg - 8'h1 == p_len_reg
        |=> !p_act_reg) else $error("Descriptor end missed");
    AST_GROUP_ONLY: assert property ($changed(llim_reg) |->
        $past(p_buf_next[79:72]) == $past(group_reg))
        else $error("Foreign group applied");
    AST_COLLIDE: assert property (lg_reg == LG_WAIT && lt.expired
        && !logon_reply && !wr_ctrl |=> att_reg == $past(att_reg) + 8'h1)
        else $error("Collision not counted");
    AST_GIVEUP: assert property (lg_reg == LG_WAIT && lt.expired
        && !logon_reply && !wr_ctrl && att_reg + 8'h1 >= llim_reg
        |=> lg_reg == LG_GIVEUP) else $error("Logon not abandoned");
    AST_BACKOFF: assert property (lg_reg == LG_WAIT
        && lg_next == LG_BACK |-> lt.load <= back_reg ##1 lg_reg == LG_BACK)
        else $error("Back-off beyond bound");
    AST_CORR_FIELDS: assert property (corr_apply |=>
        clim_reg == $past(p_buf_next[15:8]) && flim_reg ==
        $past(p_buf_next[7:0])) else $error("Bad correction parse");
    AST_COARSE_OFF: assert property (sy_reg == SY_COARSE && st.expired
        && !corr_rcvd && !wr_ctrl && closs_reg + 8'h1 >= clim_reg
        |=> sy_reg == SY_OFF && !sync_active)
        else $error("Coarse loss limit ignored");
    AST_FINE_OFF: assert property (sy_reg inside {SY_FINE, SY_MAINT}
        && st.expired && !corr_rcvd && !wr_ctrl
        && floss_reg + 8'h1 >= flim_reg |=> sy_reg == SY_OFF)
        else $error("Fine loss limit ignored");
    AST_FINE_COUNT: assert property (sy_reg inside {SY_FINE, SY_MAINT}
        && st.expired && !corr_rcvd && !wr_ctrl
        |=> floss_reg == $past(floss_reg) + 8'h1)
        else $error("Hold loss not counted");
    AST_CLEAR: assert property (sy_reg == SY_OFF
        && sy_next == SY_COARSE |=> closs_reg == 8'h0 && floss_reg == 8'h0)
        else $error("Counters not cleared");

    COV_LOGON_DONE: cover property (lg_reg == LG_WAIT ##1 lg_reg == LG_DONE);
    COV_RETRY: cover property (lg_reg == LG_BACK ##1 lg_reg == LG_ARMED);
    COV_MAINT: cover property (sy_reg == SY_FINE ##1 sy_reg == SY_MAINT);
    COV_DROP: cover property (sy_reg == SY_COARSE ##1 sy_reg == SY_OFF);
endmodule
`default_nettype wire

// [lsrc_ncc.sv]
`timescale 1ns/100ps
`default_nettype none
module lsrc_ncc (
    input  wire logic       clk,        // System clock
    output logic            desc_valid, // Byte strobe
    output logic            desc_first, // Tag byte
    output logic      [7:0] desc_byte,  // Descriptor byte
    output logic            pcr_tick,   // Reference interval
    output logic            corr_rcvd   // Correction pulse
);
    logic [1:0] div = 2'h0;
    initial begin
        desc_valid = 1'b0;
        desc_first = 1'b0;
        desc_byte = 8'h00;
        pcr_tick = 1'b0;
        corr_rcvd = 1'b0;
    end
    always @(posedge clk) begin
        div <= div + 2'h1;
        pcr_tick <= (div == 2'h3);
    end
    task automatic send(input logic [7:0] tag, input logic [79:0] p);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            desc_valid <= 1'b1;
            desc_first <= (i == 0);
            desc_byte <= i == 0 ? tag : i == 1 ? 8'h0a : p[8*(11-i)+:8];
        end
        @(posedge clk);
        desc_valid <= 1'b0;
        // Released line must not keep showing the last byte
        desc_byte <= ~desc_byte;
    endtask
    task automatic corr;
        @(posedge clk);
        corr_rcvd <= 1'b1;
        @(posedge clk);
        corr_rcvd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [lsrc_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module lsrc_top_bench;
    import lsrc_pkg::*;
    logic        clk, nrst, hsel, hwrite, logon_sent, acq_sent, rd_dp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rs;
    logic        hreadyout, hresp, desc_valid, desc_first, pcr_tick, logon_reply;
    logic        corr_rcvd, logon_req, logon_abandon, sync_active, sync_sent;
    logic [7:0]  desc_byte, grp;
    logic [31:0] exp_q[$];
    int          n_errors = 0, comparisons = 0, cyc = 0;
    lsrc_top dut (.*, .hsize(3'b010), .hready(hreadyout));
    lsrc_ncc ncc (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string w, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // For a read, d is the expected word
    task automatic bus(input logic [7:0] a, input logic w, [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (rd_dp) check("hrdata", hrdata, exp_q.pop_front());
        if (cyc == 6000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, hsel, hwrite, logon_sent, acq_sent, rd_dp} = 6'h0;
        {sync_sent, logon_reply} = 2'h0;
        {htrans, haddr, hwdata} = '0;
        rs = xs(32'h54a07a64);
        grp = rs[7:0];
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        bus(OFS_TAGS, 1'b0, {16'h0, RST_CORR_TAG, RST_CONT_TAG});
        bus(OFS_GROUP, 1'b1, {24'h0, grp});
        ncc.send(RST_CORR_TAG, {32'h3, 32'h3, 8'h2, 8'h2});
        ncc.send(RST_CONT_TAG, {grp, 32'h2, 8'h2, 32'h3});
        ncc.send(RST_CONT_TAG, {grp ^ 8'h01, 32'h9, 8'h5, 32'h9});
        bus(OFS_LIMITS, 1'b0, 32'h0002_0202);
        bus(OFS_BACKOFF, 1'b0, 32'h3);
        bus(OFS_LWAIT, 1'b0, 32'h2);
        bus(OFS_CTRL, 1'b1, 32'h1);
        @(posedge clk) acq_sent <= 1'b1;
        @(posedge clk) acq_sent <= 1'b0;
        ncc.corr();
        bus(OFS_STATUS, 1'b0, 32'h2);
        // Two fine losses, then restart and two coarse losses
        for (int i = 0; i < 4; i++) begin
            if (i == 2) begin
                bus(OFS_CTRL, 1'b1, 32'h1);
                bus(OFS_CTRL, 1'b1, 32'h4);
                bus(OFS_CTRL, 1'b1, 32'h1);
            end
            @(posedge clk) {sync_sent, acq_sent} <= (i < 2) ? 2'b10 : 2'b01;
            @(posedge clk) {sync_sent, acq_sent} <= 2'b00;
            repeat (24) @(posedge clk);
            check("sync_active", {31'h0, sync_active}, !i[0]);
        end
        bus(OFS_CTRL, 1'b1, 32'h2);
        for (int i = 0; i < 2; i++) begin
            while (logon_req !== 1'b1) @(posedge clk);
            check("logon_abandon", {31'h0, logon_abandon}, 0);
            @(posedge clk) logon_sent <= 1'b1;
            @(posedge clk) logon_sent <= 1'b0;
        end
        repeat (24) @(posedge clk);
        check("logon_abandon", {31'h0, logon_abandon}, 1);
        bus(OFS_CTRL, 1'b1, 32'h2);
        @(posedge clk) logon_sent <= 1'b1;
        @(posedge clk) {logon_sent, logon_reply} <= 2'b01;
        @(posedge clk) logon_reply <= 1'b0;
        bus(OFS_STATUS, 1'b0, 32'h0002_0040);
        end_of_test();
    end
endmodule
`default_nettype wire
